// ### inc/mtseq_params.svh
// Purpose: Constants for the trigger sequencer.
// Assumes: 125 MHz system clock.
// Notes: Times are in their own units; cycle counts derive from them.
`ifndef MTSEQ_PARAMS_SVH
`define MTSEQ_PARAMS_SVH
`define MTSEQ_CLK_HZ 125000000
`define MTSEQ_TICK_US 1
`define MTSEQ_TICK_CYC ((`MTSEQ_CLK_HZ / 1000000) * `MTSEQ_TICK_US)
`define MTSEQ_SETUP_MS 20
`define MTSEQ_SETUP_TICKS (`MTSEQ_SETUP_MS * 1000 / `MTSEQ_TICK_US)
`define MTSEQ_DELAY_MAX_S 3600
`define MTSEQ_DELAY_MAX_TICKS (`MTSEQ_DELAY_MAX_S * 1000000)
`define MTSEQ_COUNT_MAX 50000
`define MTSEQ_MEM_DEPTH 512
`define MTSEQ_RANGE_PCT 120
`define MTSEQ_DB_MAX 20000
`define MTSEQ_DBM_MIN 50
`define MTSEQ_DBM_MAX 8000
`define MTSEQ_INF_QUERY "9.90000000E+37"
`endif

// ### inc/mtseq_pkg.sv
// Purpose: Types for the trigger sequencer.
// Assumes: Readings are signed fixed-point words.
// Notes: None.
package mtseq_pkg;
   typedef enum logic [1:0] {
      MTSEQ_SRC_BUS,
      MTSEQ_SRC_IMM,
      MTSEQ_SRC_EXT
   } mtseq_src_t;
   typedef enum logic [2:0] {
      MTSEQ_MATH_NULL,
      MTSEQ_MATH_DB,
      MTSEQ_MATH_DBM,
      MTSEQ_MATH_AVER,
      MTSEQ_MATH_LIM
   } mtseq_math_t;
   typedef enum logic [3:0] {
      MTSEQ_FN_DCV,
      MTSEQ_FN_ACV,
      MTSEQ_FN_DCI,
      MTSEQ_FN_ACI,
      MTSEQ_FN_R2W,
      MTSEQ_FN_R4W,
      MTSEQ_FN_FREQ,
      MTSEQ_FN_PER,
      MTSEQ_FN_CONT,
      MTSEQ_FN_DIODE,
      MTSEQ_FN_RATIO
   } mtseq_fn_t;
   typedef struct packed {
      logic signed [31:0] value;
      logic direct;
   } mtseq_rdg_t;
   typedef struct packed {
      logic signed [31:0] min;
      logic signed [31:0] max;
      logic signed [31:0] avg;
      logic [31:0] count;
   } mtseq_stats_t;
endpackage

// ### verification/mtseq_frontend_model.sv
// Purpose: Behavioural measurement front end for the sequencer.
// Assumes: A request is held until sample_done is taken.
// Notes: Latency 0 answers promptly, 3 is the slowest.
`timescale 1ns/1ns
module mtseq_frontend_model (
   // Clock.
   input wire logic clk_sys,
   // Sample handshake.
   input wire logic sample_req,
   output logic sample_done,
   output logic signed [31:0] sample_value,
   // Bench control.
   input wire logic [1:0] lat,
   input wire logic signed [31:0] next_val
);
   // ==========================================================
   // Answer
   int wait_cnt = 0;
   initial begin
      sample_done = 1'b0;
      sample_value = 32'sh0;
   end
   // The value flips when idle, so stale data cannot pass.
   always @(negedge clk_sys) begin
      if (sample_done) begin
         sample_done <= 1'b0;
         sample_value <= ~sample_value;
      end
      else if (sample_req && wait_cnt >= lat) begin
         sample_done <= 1'b1;
         sample_value <= next_val;
         wait_cnt <= 0;
      end
      else begin
         wait_cnt <= sample_req ? wait_cnt + 1 : 0;
         sample_value <= ~sample_value;
      end
   end
endmodule

// ### verification/mtseq_top_asserts.sv
// Purpose: Port-level checks for the trigger sequencer.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound into mtseq_top; sees only its ports.
`timescale 1ns/1ns
module mtseq_top_asserts (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Requests.
   input wire logic cmd_initiate,
   input wire logic cmd_read,
   input wire logic cmd_dev_clear,
   input wire logic cmd_fetch,
   input wire logic local_mode,
   input wire logic delay_wr,
   input wire logic auto_delay_set,
   input wire logic reading_storage_target,
   input wire logic sample_done,
   input wire logic out_ready,
   // Observed outputs.
   input wire logic sample_req,
   input wire logic out_valid,
   input wire mtseq_pkg::mtseq_rdg_t out_rdg,
   input wire logic waiting,
   input wire logic idle,
   input wire logic auto_delay,
   input wire logic fetch_error,
   input wire logic [12:0] dbm_reference_resistance
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_init_to_wait: assert property (
      cmd_initiate && idle && !local_mode |=> waiting && !idle)
      else $error("initiate not waiting");
   a_read_to_wait: assert property (
      cmd_read && idle && !local_mode |=> waiting && !idle)
      else $error("read not waiting");
   a_idle_no_sample: assert property (
      idle && !local_mode |-> !sample_req)
      else $error("sample while idle");
   a_req_stands: assert property (
      sample_req && !sample_done && !cmd_dev_clear |=> sample_req)
      else $error("sample request dropped");
   a_out_stands: assert property (
      out_valid && !out_ready && !cmd_dev_clear
      |=> out_valid && $stable(out_rdg))
      else $error("output changed in stall");
   a_auto_delay_off: assert property (
      delay_wr && !auto_delay_set |=> !auto_delay)
      else $error("auto delay kept");
   a_dbm_legal: assert property (
      dbm_reference_resistance inside {13'h032, 13'h04B, 13'h05D,
      13'h06E, 13'h07C, 13'h07D, 13'h087, 13'h096, 13'h0FA, 13'h12C,
      13'h1F4, 13'h258, 13'h320, 13'h384, 13'h3E8, 13'h4B0, 13'h1F40})
      else $error("dBm value not listed");
   a_fetch_error: assert property (
      cmd_fetch && !reading_storage_target |-> ##[1:3] fetch_error)
      else $error("no fetch error");
endmodule
bind mtseq_top mtseq_top_asserts mtseq_top_asserts_inst (.*);

// ### verification/test_measurement_trigger_sequencer.sv
// Purpose: Self-checking bench for the trigger sequencer.
// Assumes: Setup and tick counts shortened to 5 ticks of 2 cycles.
// Notes: The dBm index port is 4 bits, so only 16 values are reached.
`timescale 1ns/1ns
module test_measurement_trigger_sequencer;
   // ==========================================================
   // Signals
   logic clk_sys, reset, local_mode, trig_count_inf, storage, math_state;
   logic ext_trig, out_ready, seen, sample_req, sample_done, out_valid;
   logic idle, auto_delay, math_on, fetch_error;
   logic [11:0] pls;
   logic [3:0] val_sel, dbm_index;
   logic [1:0] lat = 2'h0;
   logic [15:0] sample_count;
   logic [31:0] trig_count, delay_ticks, auto_ticks, stat_cnt;
   logic signed [31:0] full_scale, math_val, sample_value;
   logic signed [31:0] next_val = 32'sh0;
   logic signed [31:0] null_val, db_val, lower_val, upper_val;
   logic [9:0] mem_points;
   logic [12:0] dbm_res;
   mtseq_pkg::mtseq_src_t trig_source;
   mtseq_pkg::mtseq_fn_t meas_fn;
   mtseq_pkg::mtseq_math_t math_sel;
   mtseq_pkg::mtseq_rdg_t out_rdg;
   mtseq_pkg::mtseq_stats_t stats;
   logic signed [31:0] exp_q[$];
   int error_cnt = 0, checked = 0, rcv = 0, st_cnt = 0, st_min, st_max;
   int rdy = 2;
   bit exp_dir, st_on;
   integer seed = 30;
   logic [12:0] dbm_tab [16] = '{13'h032, 13'h04B, 13'h05D, 13'h06E,
      13'h07C, 13'h07D, 13'h087, 13'h096, 13'h0FA, 13'h12C, 13'h1F4,
      13'h258, 13'h320, 13'h384, 13'h3E8, 13'h4B0};
   mtseq_top #(.SETUP_TICKS(5), .TICK_CYC(2)) mtseq_top_inst (.*,
      .iface_reset(pls[11]), .cmd_initiate(pls[0]), .cmd_read(pls[1]),
      .cmd_bus_trig(pls[2]), .cmd_dev_clear(pls[3]), .cmd_fetch(pls[4]),
      .delay_wr(pls[5]), .auto_delay_set(pls[10]),
      .auto_delay_ticks(auto_ticks), .reading_storage_target(storage),
      .math_sel_wr(pls[6]), .math_state_wr(pls[7]), .math_val_wr(pls[8]),
      .null_wr(val_sel[0]), .db_wr(val_sel[1]), .dbm_wr(pls[9]),
      .lower_wr(val_sel[2]), .upper_wr(val_sel[3]), .waiting(),
      .math_fn(), .mem_rd_data(), .null_offset_value(null_val),
      .db_relative_value(db_val), .dbm_reference_resistance(dbm_res),
      .lower_limit_threshold(lower_val), .upper_limit_threshold(upper_val),
      .statistics_reading_count(stat_cnt));
   mtseq_frontend_model mtseq_frontend_model_inst (.*);
   // ==========================================================
   // Clock, random drive and reference model
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) begin
      next_val <= $random(seed) % 1000;
      lat <= 2'($random(seed));
      out_ready <= rdy == 2 || (rdy == 1 && $random(seed) % 2 == 0);
   end
   always @(posedge clk_sys) begin
      if (!reset && sample_done === 1'b1 && sample_req === 1'b1) begin
         rcv++;
         if (exp_dir)
            exp_q.push_back(sample_value);
         if (st_on) begin
            if (st_cnt == 0 || sample_value < st_min)
               st_min = sample_value;
            if (st_cnt == 0 || sample_value > st_max)
               st_max = sample_value;
            st_cnt++;
         end
      end
      if (!reset && out_valid === 1'b1 && out_ready === 1'b1) begin
         if (exp_q.size() == 0)
            chk("unexpected_out", 0, 1);
         else begin
            chk("reading", exp_q.pop_front(), out_rdg.value);
            chk("direct", 1, out_rdg.direct);
         end
      end
   end
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic fail(input string nm);
      chk(nm, 1, 0);
      summarize();
   endtask
   // Two edges per pulse, so no strobe drops and rises at once.
   task automatic pulse(input int i);
      pls[i] = 1'b1;
      @(negedge clk_sys);
      pls[i] = 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic wait_idle(input int bound);
      for (int n = 0; idle !== 1'b1; n++) begin
         if (n == bound)
            fail("idle_timeout");
         @(negedge clk_sys);
      end
   endtask
   task automatic wait_req(input int lo, input int hi);
      int n;
      for (n = 0; sample_req !== 1'b1; n++) begin
         if (n == hi)
            fail("req_timeout");
         @(negedge clk_sys);
      end
      chk("req_early", 0, n < lo);
   endtask
   task automatic quiet(input int n);
      repeat (n) begin
         chk("no_req", 0, sample_req);
         @(negedge clk_sys);
      end
   endtask
   task automatic drain(input string nm);
      for (int n = 0; exp_q.size() != 0 && n < 60; n++)
         @(negedge clk_sys);
      chk("left", 0, exp_q.size());
      $display("Test %s done", nm);
   endtask
   task automatic wval(input int s, input logic signed [31:0] v);
      val_sel[s] = 1'b1;
      math_val = v;
      pulse(8);
      val_sel = 4'h0;
   endtask
   // ==========================================================
   // Scenarios
   initial begin
      pls = 12'h000;
      val_sel = 4'h0;
      dbm_index = 4'h0;
      local_mode = 1'b0;
      trig_count_inf = 1'b0;
      storage = 1'b1;
      math_state = 1'b0;
      ext_trig = 1'b0;
      out_ready = 1'b1;
      sample_count = 16'h0003;
      trig_count = 32'h2;
      delay_ticks = 32'h0;
      auto_ticks = 32'h0;
      full_scale = 32'sh3E8;
      math_val = 32'sh0;
      trig_source = mtseq_pkg::MTSEQ_SRC_IMM;
      meas_fn = mtseq_pkg::MTSEQ_FN_DCV;
      math_sel = mtseq_pkg::MTSEQ_MATH_AVER;
      reset = 1'b1;
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      @(negedge clk_sys);
      chk("idle", 1, idle);
      chk("auto_delay", 1, auto_delay);
      chk("count", 0, stats.count);
      pulse(5);
      chk("auto_delay", 0, auto_delay);
      rdy = 0;
      exp_dir = 1;
      pulse(1);
      repeat (60) @(negedge clk_sys);
      rdy = 1;
      wait_idle(400);
      rdy = 2;
      drain("read_stalled");
      chk("readings", 6, rcv);
      exp_dir = 0;
      pulse(0);
      wait_idle(200);
      chk("points", 6, mem_points);
      $display("Test initiate done");
      pulse(6);
      math_state = 1'b1;
      pulse(7);
      st_on = 1;
      sample_count = 16'h0004;
      trig_count = 32'h1;
      pulse(0);
      wait_idle(200);
      chk("min", st_min, stats.min);
      chk("max", st_max, stats.max);
      chk("count", st_cnt, stat_cnt);
      math_state = 1'b0;
      pulse(7);
      math_state = 1'b1;
      pulse(7);
      chk("count", 0, stats.count);
      st_cnt = 0;
      storage = 1'b0;
      pulse(0);
      wait_idle(200);
      chk("count", st_cnt, stats.count);
      chk("max", st_max, stats.max);
      fork
         pulse(4);
         begin
            @(negedge clk_sys);
            seen = fetch_error;
         end
      join
      chk("fetch_error", 1, seen);
      pulse(11);
      chk("count", 0, stats.count);
      st_on = 0;
      storage = 1'b1;
      $display("Test statistics done");
      trig_source = mtseq_pkg::MTSEQ_SRC_BUS;
      sample_count = 16'h0001;
      exp_dir = 1;
      pulse(2);
      pulse(1);
      quiet(6);
      pulse(2);
      wait_req(0, 4);
      wait_idle(40);
      drain("bus_trigger");
      trig_source = mtseq_pkg::MTSEQ_SRC_EXT;
      trig_count = 32'h2;
      pulse(1);
      ext_trig = 1'b1;
      quiet(20);
      ext_trig = 1'b0;
      repeat (3) @(negedge clk_sys);
      ext_trig = 1'b1;
      wait_req(1, 10);
      repeat (8) @(negedge clk_sys);
      quiet(20);
      ext_trig = 1'b0;
      repeat (3) @(negedge clk_sys);
      ext_trig = 1'b1;
      wait_req(1, 10);
      wait_idle(40);
      ext_trig = 1'b0;
      drain("external_trigger");
      trig_source = mtseq_pkg::MTSEQ_SRC_IMM;
      trig_count = 32'h1;
      delay_ticks = 32'h3;
      pulse(5);
      pulse(1);
      wait_req(5, 12);
      wait_idle(40);
      pulse(10);
      chk("auto_delay", 1, auto_delay);
      delay_ticks = 32'h0;
      pulse(5);
      drain("delay");
      trig_count_inf = 1'b1;
      rdy = 1;
      pulse(1);
      repeat (60) @(negedge clk_sys);
      chk("idle", 0, idle);
      pulse(3);
      wait_idle(40);
      rdy = 2;
      repeat (20) @(negedge clk_sys);
      exp_q.delete();
      trig_count_inf = 1'b0;
      $display("Test infinite done");
      math_sel = mtseq_pkg::MTSEQ_MATH_NULL;
      pulse(6);
      pulse(7);
      wval(0, 32'sh1388);
      chk("null", 32'sh4B0, null_val);
      wval(2, -32'sh2328);
      chk("lower", -32'sh4B0, lower_val);
      wval(3, 32'sh2BC);
      chk("upper", 32'sh2BC, upper_val);
      math_sel = mtseq_pkg::MTSEQ_MATH_DB;
      pulse(6);
      wval(1, 32'sh7530);
      chk("db", 32'sh4E20, db_val);
      wval(1, -32'sh7530);
      chk("db", -32'sh4E20, db_val);
      chk("dbm", 32'h258, dbm_res);
      for (int i = 0; i < 16; i++) begin
         dbm_index = 4'(i);
         pulse(9);
         chk("dbm", dbm_tab[i], dbm_res);
      end
      meas_fn = mtseq_pkg::MTSEQ_FN_DCI;
      pulse(6);
      chk("math_on", 0, math_on);
      $display("Test math done");
      summarize();
   end
   initial begin
      #400000;
      fail("run_timeout");
   end
endmodule

// ### verilog/mtseq_fifo.sv
// Purpose: Small ready/valid FIFO for the reading path.
// Assumes: One clock, synchronous active-high reset.
// Notes: Full and empty are exact; no bypass path.
`timescale 1ns/1ns
module mtseq_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 4
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_q];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ### verilog/mtseq_top.sv
// Purpose: Trigger sequencer, reading memory and math registers.
// Assumes: Commands arrive as one-cycle pulses from the bus controller.
// Notes: Limits and offsets are checked against a full-scale input.
`timescale 1ns/1ns
`include "mtseq_params.svh"
module mtseq_top #(
   parameter int SETUP_TICKS = `MTSEQ_SETUP_TICKS,
   parameter int TICK_CYC = `MTSEQ_TICK_CYC,
   parameter int MEM_DEPTH = `MTSEQ_MEM_DEPTH,
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic iface_reset,
   // Commands.
   input wire logic cmd_initiate,
   input wire logic cmd_read,
   input wire logic cmd_bus_trig,
   input wire logic cmd_dev_clear,
   input wire logic cmd_fetch,
   input wire logic local_mode,
   // Configuration.
   input wire mtseq_pkg::mtseq_src_t trig_source,
   input wire logic [31:0] trig_count,
   input wire logic trig_count_inf,
   input wire logic [15:0] sample_count,
   input wire logic delay_wr,
   input wire logic [31:0] delay_ticks,
   input wire logic auto_delay_set,
   input wire logic [31:0] auto_delay_ticks,
   input wire logic reading_storage_target,
   input wire mtseq_pkg::mtseq_fn_t meas_fn,
   input wire logic math_sel_wr,
   input wire mtseq_pkg::mtseq_math_t math_sel,
   input wire logic math_state_wr,
   input wire logic math_state,
   input wire logic signed [31:0] full_scale,
   input wire logic math_val_wr,
   input wire logic signed [31:0] math_val,
   input wire logic null_wr,
   input wire logic db_wr,
   input wire logic dbm_wr,
   input wire logic [3:0] dbm_index,
   input wire logic lower_wr,
   input wire logic upper_wr,
   // External trigger pin.
   input wire logic ext_trig,
   // Measurement front end.
   output logic sample_req,
   input wire logic sample_done,
   input wire logic signed [31:0] sample_value,
   // Output buffer side.
   output logic out_valid,
   input wire logic out_ready,
   output mtseq_pkg::mtseq_rdg_t out_rdg,
   // Status.
   output logic waiting,
   output logic idle,
   output logic auto_delay,
   output logic math_on,
   output mtseq_pkg::mtseq_math_t math_fn,
   output logic fetch_error,
   output logic [9:0] mem_points,
   output logic signed [31:0] mem_rd_data,
   output mtseq_pkg::mtseq_stats_t stats,
   output logic signed [31:0] null_offset_value,
   output logic signed [31:0] db_relative_value,
   output logic [12:0] dbm_reference_resistance,
   output logic signed [31:0] lower_limit_threshold,
   output logic signed [31:0] upper_limit_threshold,
   output logic [31:0] statistics_reading_count
);
   // ===========================================================
   // External trigger synchroniser
   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;
   logic ext_pulse;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= ext_trig;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end
   assign ext_pulse = ext_s2_q && !ext_s3_q;

   // ===========================================================
   // Fixed-rate tick
   logic [15:0] pre_q;
   logic tick;
   assign tick = (pre_q == 16'(TICK_CYC - 1));
   always_ff @(posedge clk_sys) begin
      if (reset || tick) begin
         pre_q <= 16'h0000;
      end else begin
         pre_q <= pre_q + 16'h0001;
      end
   end

   // ===========================================================
   // Sequencer
   typedef enum {
      ST_IDLE,
      ST_WAIT,
      ST_DELAY,
      ST_SAMPLE,
      ST_STORE
   } mtseq_st_t;
   mtseq_st_t st_q;
   logic [31:0] tmr_q;
   logic [15:0] samp_q;
   logic [31:0] trg_q;
   logic direct_q;
   logic [31:0] delay_q;
   logic trig_seen;
   logic go_wait;
   logic fifo_ready;
   logic signed [31:0] rdg_q;
   logic last_trig;
   assign go_wait = (cmd_initiate || cmd_read) && st_q == ST_IDLE;
   always_comb begin
      case (trig_source)
         mtseq_pkg::MTSEQ_SRC_BUS: trig_seen = cmd_bus_trig;
         mtseq_pkg::MTSEQ_SRC_EXT: trig_seen = ext_pulse && tmr_q == '0;
         default: trig_seen = 1'b1;
      endcase
   end
   assign last_trig = !local_mode && !trig_count_inf
      && trg_q + 32'h1 >= trig_count;
   assign idle = (st_q == ST_IDLE);
   assign waiting = (st_q == ST_WAIT);
   assign sample_req = (st_q == ST_SAMPLE);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         delay_q <= 32'h0000_0000;
         auto_delay <= 1'b1;
      end else if (delay_wr) begin
         delay_q <= (delay_ticks > 32'(`MTSEQ_DELAY_MAX_TICKS))
            ? 32'(`MTSEQ_DELAY_MAX_TICKS) : delay_ticks;
         auto_delay <= 1'b0;
      end else if (auto_delay_set) begin
         auto_delay <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset || cmd_dev_clear || iface_reset) begin
         st_q <= ST_IDLE;
         tmr_q <= 32'h0000_0000;
         samp_q <= 16'h0000;
         trg_q <= 32'h0000_0000;
         direct_q <= 1'b0;
         rdg_q <= 32'sh0000_0000;
      end else begin
         if (tmr_q != '0 && tick && st_q != ST_DELAY) begin
            tmr_q <= tmr_q - 32'h1;
         end
         case (st_q)
            ST_IDLE: begin
               if (local_mode) begin
                  st_q <= ST_WAIT;
               end else if (go_wait) begin
                  st_q <= ST_WAIT;
                  direct_q <= cmd_read;
                  tmr_q <= 32'(SETUP_TICKS);
                  trg_q <= 32'h0000_0000;
               end
            end
            ST_WAIT: begin
               if (trig_seen) begin
                  st_q <= ST_DELAY;
                  samp_q <= 16'h0000;
                  tmr_q <= auto_delay ? auto_delay_ticks : delay_q;
               end
            end
            ST_DELAY: begin
               if (tmr_q == '0) begin
                  st_q <= ST_SAMPLE;
               end else if (tick) begin
                  tmr_q <= tmr_q - 32'h1;
               end
            end
            ST_SAMPLE: begin
               if (sample_done) begin
                  rdg_q <= sample_value;
                  st_q <= ST_STORE;
               end
            end
            ST_STORE: begin
               if (!direct_q || fifo_ready) begin
                  if (samp_q + 16'h1 < sample_count) begin
                     samp_q <= samp_q + 16'h1;
                     tmr_q <= auto_delay ? auto_delay_ticks : delay_q;
                     st_q <= ST_DELAY;
                  end else if (last_trig) begin
                     st_q <= ST_IDLE;
                  end else begin
                     trg_q <= trg_q + 32'h1;
                     st_q <= ST_WAIT;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   logic store_done;
   assign store_done = st_q == ST_STORE && (!direct_q || fifo_ready);

   // ===========================================================
   // Direct output path
   mtseq_pkg::mtseq_rdg_t fifo_in;
   assign fifo_in = '{value: rdg_q, direct: 1'b1};
   mtseq_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(st_q == ST_STORE && direct_q),
      .in_ready(fifo_ready),
      .in_data(fifo_in),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_rdg)
   );

   // ===========================================================
   // Reading memory
   logic signed [31:0] mem_q [MEM_DEPTH];
   logic [9:0] rd_ptr_q;
   always_ff @(posedge clk_sys) begin
      if (store_done && !direct_q && reading_storage_target
          && mem_points < 10'(MEM_DEPTH)) begin
         mem_q[mem_points[8:0]] <= rdg_q;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset || iface_reset || go_wait) begin
         mem_points <= 10'h000;
         rd_ptr_q <= 10'h000;
         fetch_error <= 1'b0;
         mem_rd_data <= 32'sh0000_0000;
      end else begin
         fetch_error <= cmd_fetch && !reading_storage_target;
         if (store_done && !direct_q && reading_storage_target
             && mem_points < 10'(MEM_DEPTH)) begin
            mem_points <= mem_points + 10'h001;
         end
         if (cmd_fetch && reading_storage_target
             && rd_ptr_q < mem_points) begin
            mem_rd_data <= mem_q[rd_ptr_q[8:0]];
            rd_ptr_q <= rd_ptr_q + 10'h001;
         end
      end
   end

   // ===========================================================
   // Math selection and settings
   logic fn_ok;
   always_comb begin
      case (math_sel)
         mtseq_pkg::MTSEQ_MATH_NULL:
            fn_ok = meas_fn <= mtseq_pkg::MTSEQ_FN_PER;
         mtseq_pkg::MTSEQ_MATH_DB, mtseq_pkg::MTSEQ_MATH_DBM:
            fn_ok = meas_fn <= mtseq_pkg::MTSEQ_FN_ACV;
         default:
            fn_ok = meas_fn <= mtseq_pkg::MTSEQ_FN_PER
               || meas_fn == mtseq_pkg::MTSEQ_FN_RATIO;
      endcase
   end
   logic stats_clr;
   assign stats_clr = reset || iface_reset
      || (math_state_wr && math_state
          && math_fn == mtseq_pkg::MTSEQ_MATH_AVER);
   logic signed [31:0] lim_hi;
   logic signed [31:0] clamped;
   assign lim_hi = 32'((64'(full_scale) * `MTSEQ_RANGE_PCT) / 100);
   assign clamped = math_val > lim_hi ? lim_hi
      : (math_val < -lim_hi ? -lim_hi : math_val);

   always_ff @(posedge clk_sys) begin
      if (reset || iface_reset) begin
         math_fn <= mtseq_pkg::MTSEQ_MATH_NULL;
         math_on <= 1'b0;
      end else if (math_sel_wr) begin
         math_fn <= math_sel;
         if (!fn_ok) begin
            math_on <= 1'b0;
         end
      end else if (math_state_wr) begin
         math_on <= math_state;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset || iface_reset) begin
         null_offset_value <= 32'sh0000_0000;
         db_relative_value <= 32'sh0000_0000;
         lower_limit_threshold <= 32'sh0000_0000;
         upper_limit_threshold <= 32'sh0000_0000;
      end else if (math_val_wr) begin
         if (null_wr && math_on) begin
            null_offset_value <= clamped;
         end
         if (db_wr && math_on) begin
            db_relative_value <= math_val > 32'sd`MTSEQ_DB_MAX
               ? 32'sd`MTSEQ_DB_MAX : (math_val < -32'sd`MTSEQ_DB_MAX
               ? -32'sd`MTSEQ_DB_MAX : math_val);
         end
         if (lower_wr) begin
            lower_limit_threshold <= clamped;
         end
         if (upper_wr) begin
            upper_limit_threshold <= clamped;
         end
      end
   end

   // Non-volatile in the instrument; here it only survives soft resets.
   logic [12:0] dbm_tab [17];
   assign dbm_tab = '{13'd50, 13'd75, 13'd93, 13'd110, 13'd124, 13'd125,
      13'd135, 13'd150, 13'd250, 13'd300, 13'd500, 13'd600, 13'd800,
      13'd900, 13'd1000, 13'd1200, 13'd8000};
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dbm_reference_resistance <= 13'h0258;
      end else if (dbm_wr) begin
         dbm_reference_resistance <= dbm_tab[dbm_index > 4'hF ?
            5'h10 : {1'b0, dbm_index}];
      end
   end

   // ===========================================================
   // Min-max statistics
   logic signed [63:0] sum_q;
   logic stat_upd;
   assign stat_upd = store_done && math_on
      && math_fn == mtseq_pkg::MTSEQ_MATH_AVER;
   assign statistics_reading_count = stats.count;
   always_ff @(posedge clk_sys) begin
      if (stats_clr) begin
         stats <= '0;
         sum_q <= 64'sh0;
      end else if (stat_upd) begin
         if (stats.count == '0 || rdg_q < stats.min) begin
            stats.min <= rdg_q;
         end
         if (stats.count == '0 || rdg_q > stats.max) begin
            stats.max <= rdg_q;
         end
         sum_q <= sum_q + 64'(rdg_q);
         stats.count <= stats.count + 32'h1;
         stats.avg <= 32'((sum_q + 64'(rdg_q))
            / $signed({32'h0, stats.count + 32'h1}));
      end
   end
endmodule
